// >>> dv/hps_msg_sink.sv
`timescale 1ns/1ps
// Downstream message receiver; stalls at random like a busy link
module hps_msg_sink (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Message port
    input  wire logic              msg_valid,
    input  wire hps_pkg::hps_msg_t msg,
    output logic                   msg_ready
);
    import hps_pkg::*;

    hps_msg_t got[$];

    // Each accepted handover is one message, never merged
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_ready <= 1'b0;
        end else begin
            if (msg_valid && msg_ready) begin
                got.push_back(msg);
            end
            msg_ready <= ($urandom % 3) != 0;
        end
    end
endmodule

// >>> dv/hps_slot_regs_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module hps_slot_regs_test;
    import hps_pkg::*;

    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        ld_valid, cmd_done, dl_active, hp_irq, hp_wake, cmd_issue;
    logic        pwr_off, lock, msg_valid, msg_ready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cap_exp;
    logic [3:0]  pstrb;
    logic [1:0]  attn_ind, pwr_ind;
    logic [12:0] ctl_exp;
    logic [5:0]  en;
    hps_cap_t    ld_data;
    hps_evt_t    evt;
    hps_msg_t    msg;
    int          miscompares, comparisons;

    hps_slot_regs u_hps_slot_regs (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .ld_valid(ld_valid), .ld_data(ld_data),
        .evt(evt), .cmd_done(cmd_done), .dl_active(dl_active), .hp_irq(hp_irq),
        .hp_wake(hp_wake), .cmd_issue(cmd_issue), .pwr_off(pwr_off),
        .electromechanical_lock_ctl(lock), .attn_ind(attn_ind), .pwr_ind(pwr_ind),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg(msg));
    hps_msg_sink u_hps_msg_sink (.clk(clk), .rst_n(rst_n), .msg_valid(msg_valid), .msg(msg),
        .msg_ready(msg_ready));

    always #2.5 clk = ~clk;

    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction
    function automatic logic [31:0] cap_word(input hps_cap_t c);
        return {c.slot_num, 2'h0, c.pwr_scale, c.pwr_val, c.hp_capable, 6'h00};
    endfunction

    task automatic finish_test;
        $display("counts: comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Holds the request until pready; one idle cycle keeps drivers single per step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 40);
        if (n >= 40) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_msgs(input int n);
        for (int i = 0; i < 40 && u_hps_msg_sink.got.size() < n; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        `CHK(u_hps_msg_sink.got.size(), n)
    endtask

    task automatic wr_cap(input logic [31:0] d, input logic [3:0] s);
        logic [31:0] bm;
        hps_msg_t    m;
        bm = lane_mask(s) & 32'h0001ff80;
        cap_exp = (cap_exp & ~bm) | (d & bm);
        apb(1'b1, ADDR_SLOT_CAP, d, s);
        wait_msgs(bm != 0);
        if (bm != 0) begin
            m = u_hps_msg_sink.got[0];
            `CHK(m.kind, HPS_MSG_PWR_LIMIT)
            `CHK({m.pwr_scale, m.pwr_val}, cap_exp[16:7])
        end
        u_hps_msg_sink.got.delete();
        apb(1'b0, ADDR_SLOT_CAP, 32'h0, 4'h0);
        `CHK(rd, cap_exp)
    endtask

    task automatic wr_ctl(input logic [31:0] d, input logic [3:0] s);
        logic [12:0] m13;
        int          k;
        m13 = {{5{s[1]}}, {8{s[0]}}};
        ctl_exp = (ctl_exp & ~m13) | (d[12:0] & m13);
        apb(1'b1, ADDR_SLOT_CTL, d, s);
        `CHK(cmd_issue, s[1:0] != 2'h0)
        `CHK(attn_ind, ctl_exp[7:6])
        `CHK(pwr_ind, ctl_exp[9:8])
        `CHK(pwr_off, ctl_exp[10])
        `CHK(lock, ctl_exp[11])
        k = 0;
        wait_msgs((s[0] && ctl_exp[7:6] != 0) + (s[1] && ctl_exp[9:8] != 0));
        if (s[0] && ctl_exp[7:6] != 0) begin
            `CHK(u_hps_msg_sink.got[k].kind, HPS_MSG_ATTN_IND)
            `CHK(u_hps_msg_sink.got[k].ind, ctl_exp[7:6])
            k++;
        end
        if (s[1] && ctl_exp[9:8] != 0) begin
            `CHK(u_hps_msg_sink.got[k].kind, HPS_MSG_PWR_IND)
            `CHK(u_hps_msg_sink.got[k].ind, ctl_exp[9:8])
        end
        u_hps_msg_sink.got.delete();
        apb(1'b0, ADDR_SLOT_CTL, 32'h0, 4'h0);
        `CHK(rd, {19'h0, ctl_exp})
    endtask

    task automatic pulse(input hps_evt_t ev, input logic cd, input logic ei, input logic ew);
        evt <= ev;
        cmd_done <= cd;
        @(posedge clk);
        evt <= '0;
        cmd_done <= 1'b0;
        @(posedge clk);
        `CHK(hp_irq, ei)
        `CHK(hp_wake, ew)
    endtask

    initial begin
        #200000;
        miscompares++;
        finish_test;
    end

    initial begin
        clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; pstrb = '0; ld_valid = 1'b0; ld_data = '0;
        evt = '0; cmd_done = 1'b0; dl_active = 1'b0;
        void'($urandom(3));
        cap_exp = cap_word({RST_HP_CAPABLE, RST_PWR_VAL, RST_PWR_SCALE, RST_SLOT_NUM});
        ctl_exp = RST_SLOT_CTL;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK(attn_ind, IND_OFF)
        `CHK(pwr_ind, IND_ON)
        apb(1'b0, ADDR_SLOT_CAP, 32'h0, 4'h0);
        `CHK(rd, 32'h00000cc0)
        apb(1'b0, ADDR_SLOT_CTL, 32'h0, 4'h0);
        `CHK(rd, 32'h000001c0)
        $display("test reset values done");
        // Rewriting the same value must still send a message
        wr_cap(32'hffffffff, 4'hf);
        wr_cap(32'hffffffff, 4'h1);
        wr_cap(32'h00000000, 4'h8);
        repeat (6) wr_cap($urandom, 4'($urandom));
        $display("test capability writes done");
        for (int c = 0; c < 4; c++) wr_ctl({22'h0, 2'(c), 2'(c), 6'h00}, 4'h3);
        wr_ctl(32'hffffffff, 4'h3);
        repeat (6) wr_ctl($urandom, 4'($urandom));
        // No drain between writes: a busy link must stall the bus, never merge
        ctl_exp[12:6] = {1'b1, ctl_exp[11:10], IND_OFF, IND_BLINK};
        repeat (4) apb(1'b1, ADDR_SLOT_CTL, {19'h0, ctl_exp}, 4'h3);
        wait_msgs(8);
        for (int j = 0; j < 8; j++) begin
            `CHK(u_hps_msg_sink.got[j].kind, j[0] ? HPS_MSG_PWR_IND : HPS_MSG_ATTN_IND)
            `CHK(u_hps_msg_sink.got[j].ind, j[0] ? IND_OFF : IND_BLINK)
        end
        u_hps_msg_sink.got.delete();
        $display("test control writes done");
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 3; k++) begin
                en = (k == 0) ? 6'(32 | (1 << i)) : (k == 1) ? 6'(1 << i) : 6'(63 & ~(1 << i));
                wr_ctl({19'h0, ctl_exp[12:6], en}, 4'h1);
                pulse(hps_evt_t'(4'h8 >> i), 1'b0, k == 0, k != 2);
            end
        end
        wr_ctl({19'h0, ctl_exp[12:6], 6'h30}, 4'h1);
        pulse('0, 1'b1, 1'b1, 1'b0);
        apb(1'b0, ADDR_SLOT_CTL, 32'h0, 4'h0);
        `CHK(rd[20], 1'b1)
        apb(1'b1, ADDR_SLOT_CTL, 32'h00100000, 4'h4);
        dl_active <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(hp_irq, ctl_exp[12])
        `CHK(hp_wake, 1'b0)
        repeat (2) @(posedge clk);
        apb(1'b0, ADDR_SLOT_CTL, 32'h0, 4'h0);
        `CHK(rd, {7'h0, 1'b1, 11'h0, ctl_exp})
        apb(1'b1, ADDR_SLOT_CTL, 32'h01000000, 4'h8);
        apb(1'b0, ADDR_SLOT_CTL, 32'h0, 4'h0);
        `CHK(rd, {19'h0, ctl_exp})
        $display("test events done");
        apb(1'b1, 12'h0dc, 32'hffffffff, 4'hf);
        `CHK(err, 1'b1)
        apb(1'b0, 12'h0dc, 32'h0, 4'h0);
        `CHK(rd, 32'h0)
        ld_valid <= 1'b1;
        ld_data <= hps_cap_t'($urandom);
        @(posedge clk);
        ld_valid <= 1'b0;
        cap_exp = cap_word(ld_data);
        wait_msgs(0);
        apb(1'b0, ADDR_SLOT_CAP, 32'h0, 4'h0);
        `CHK(rd, cap_exp)
        $display("test loader and unmapped done");
        finish_test;
    end
endmodule

// >>> logic/hps_pkg.sv
package hps_pkg;
    // Bus geometry
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] ADDR_SLOT_CAP   = 12'h0d4;
    localparam logic [11:0] ADDR_SLOT_CTL   = 12'h0d8;

    // Slot capability field positions
    localparam int CAP_HP_CAPABLE_BIT = 6;
    localparam int CAP_PWR_VAL_LSB    = 7;
    localparam int CAP_PWR_VAL_MSB    = 14;
    localparam int CAP_PWR_SCALE_LSB  = 15;
    localparam int CAP_PWR_SCALE_MSB  = 16;
    localparam int CAP_SLOT_NUM_LSB   = 19;
    localparam int CAP_SLOT_NUM_MSB   = 31;

    // Slot capability reset values
    localparam logic        RST_HP_CAPABLE = 1'b1;
    localparam logic [7:0]  RST_PWR_VAL    = 8'h19;
    localparam logic [1:0]  RST_PWR_SCALE  = 2'h0;
    localparam logic [12:0] RST_SLOT_NUM   = 13'h0000;

    // Slot control field positions
    localparam int CTL_ATTN_BTN_EN = 0;
    localparam int CTL_PWR_FLT_EN  = 1;
    localparam int CTL_LATCH_EN    = 2;
    localparam int CTL_PRES_EN     = 3;
    localparam int CTL_CMD_CPL_EN  = 4;
    localparam int CTL_HP_INT_EN   = 5;
    localparam int CTL_ATTN_LSB    = 6;
    localparam int CTL_PIND_LSB    = 8;
    localparam int CTL_PWR_OFF     = 10;
    localparam int CTL_EM_LOCK     = 11;
    localparam int CTL_DLL_EN      = 12;
    localparam int CTL_W           = 13;

    // Slot control reset value: indicators off / on, everything else clear
    localparam logic [12:0] RST_SLOT_CTL = 13'h01c0;

    // Slot status bits in the upper half of the control word
    localparam int ST_CMD_CPL_BIT = 20;
    localparam int ST_DLL_CHG_BIT = 24;

    // Indicator encodings
    localparam logic [1:0] IND_RSVD  = 2'h0;
    localparam logic [1:0] IND_ON    = 2'h1;
    localparam logic [1:0] IND_BLINK = 2'h2;
    localparam logic [1:0] IND_OFF   = 2'h3;

    typedef enum logic [1:0] {
        HPS_MSG_PWR_LIMIT = 2'h0,
        HPS_MSG_ATTN_IND  = 2'h1,
        HPS_MSG_PWR_IND   = 2'h2
    } hps_msg_kind_t;

    typedef struct packed {
        hps_msg_kind_t kind;
        logic [1:0]    ind;
        logic [7:0]    pwr_val;
        logic [1:0]    pwr_scale;
    } hps_msg_t;

    typedef struct packed {
        logic        hp_capable;
        logic [7:0]  pwr_val;
        logic [1:0]  pwr_scale;
        logic [12:0] slot_num;
    } hps_cap_t;

    typedef struct packed {
        logic attn_button;
        logic power_fault;
        logic retention_latch_sensor;
        logic presence_change;
    } hps_evt_t;
endpackage

// >>> logic/hps_slot_regs.sv
`timescale 1ns/1ps
// Operation
// - Hot-plug capable flag, read-only, resets one
// - Power limit value bits 14:7, reset 19h
// - Power limit scale bits 16:15, reset 00b
// - Limit field write sends power-limit message
// - Read-only slot number bits 31:19, reset zero
// - Capability defaults reloadable by serial loader
// - Bit 0 enables attention button event
// - Bit 1 enables power fault event
// - Bit 2 enables retention latch change event
// - Bit 3 enables presence change event
// - Bit 4 enables command-complete interrupt, no wake
// - Bit 5 is master hot-plug interrupt enable
// - Attention indicator 7:6, reset off (11b)
// - Attention field write of a non-reserved code (not 00b) sends indicator message
// - Power indicator 9:8, reset on (01b)
// - Power indicator write of a non-reserved code (not 00b) sends indicator message
// - Bit 10 clear powers on, set off
// - Bit 12 enables link-active change notification
// - Link-active change sets sticky W1C flag
// - Command completion sets sticky W1C flag
module hps_slot_regs #(
    parameter bit DLL_ACTIVE_CAP = 1'b1
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [hps_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    // Capability default loader
    input  wire logic                       ld_valid,
    input  wire hps_pkg::hps_cap_t          ld_data,
    // Slot events and controller status
    input  wire hps_pkg::hps_evt_t          evt,
    input  wire logic                       cmd_done,
    input  wire logic                       dl_active,
    // Hot-plug notification
    output logic                            hp_irq,
    output logic                            hp_wake,
    output logic                            cmd_issue,
    // Slot control outputs
    output logic                            pwr_off,
    output logic                            electromechanical_lock_ctl,
    output logic [1:0]                      attn_ind,
    output logic [1:0]                      pwr_ind,
    // Downstream message request
    output logic                            msg_valid,
    input  wire logic                       msg_ready,
    output hps_pkg::hps_msg_t               msg
);
    import hps_pkg::*;

    // State
    hps_cap_t          cap_ff,      nxt_cap;
    logic [CTL_W-1:0]  ctl_ff,      nxt_ctl;
    logic              cc_st_ff,    nxt_cc_st;
    logic              dll_st_ff,   nxt_dll_st;
    logic              dl_meta_ff;
    logic              dl_sync_ff;
    logic              dl_prev_ff;
    logic              pend_pl_ff,  nxt_pend_pl;
    logic              pend_ai_ff,  nxt_pend_ai;
    logic              pend_pi_ff,  nxt_pend_pi;
    logic              msg_vld_ff,  nxt_msg_vld;
    hps_msg_t          msg_ff,      nxt_msg;
    logic [31:0]       rdata_ff,    nxt_rdata;
    logic              irq_ff,      nxt_irq;
    logic              wake_ff,     nxt_wake;
    logic              issue_ff,    nxt_issue;

    // Decode
    wire        cap_hit   = (paddr == ADDR_SLOT_CAP);
    wire        ctl_hit   = (paddr == ADDR_SLOT_CTL);
    wire        mapped    = cap_hit | ctl_hit;
    wire        access    = psel & penable;
    wire [31:0] bmask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire        lim_touch = |bmask[CAP_PWR_SCALE_MSB:CAP_PWR_VAL_LSB];
    wire        ai_touch  = pstrb[0];
    wire        pi_touch  = pstrb[1];

    // A write that would queue a second copy of a message still waiting is held
    // in its access phase; merging would silently lose one of the two.
    wire        wr_block  = pwrite & ((cap_hit & lim_touch & pend_pl_ff)
                                    | (ctl_hit & ai_touch & pend_ai_ff)
                                    | (ctl_hit & pi_touch & pend_pi_ff));
    assign pready  = ~(access & wr_block);
    assign pslverr = access & ~mapped;
    assign prdata  = rdata_ff;

    wire        wr_fire   = access & pwrite & pready;
    wire        cap_wr    = wr_fire & cap_hit;
    wire        ctl_wr    = wr_fire & ctl_hit;

    // Read data, captured in the setup phase
    wire [31:0] cap_word  = {cap_ff.slot_num, 2'b00, cap_ff.pwr_scale, cap_ff.pwr_val,
                             cap_ff.hp_capable, 6'h00};
    wire [31:0] ctl_word  = {7'h00, dll_st_ff, 3'h0, cc_st_ff, 4'h0, 3'h0, ctl_ff};
    assign nxt_rdata = (psel & ~penable & ~pwrite) ?
                       (cap_hit ? cap_word : (ctl_hit ? ctl_word : 32'h0000_0000)) : rdata_ff;

    // Capability fields: loader wins, software reaches only the limit fields
    wire [31:0] cap_merge = (cap_word & ~bmask) | (pwdata & bmask);
    always_comb begin
        nxt_cap = cap_ff;
        if (ld_valid) begin
            nxt_cap = ld_data;
        end else if (cap_wr) begin
            nxt_cap.pwr_val   = cap_merge[CAP_PWR_VAL_MSB:CAP_PWR_VAL_LSB];
            nxt_cap.pwr_scale = cap_merge[CAP_PWR_SCALE_MSB:CAP_PWR_SCALE_LSB];
        end
    end

    // Slot control: low thirteen bits writable per byte lane
    wire [15:0] ctl_merge = ({3'b000, ctl_ff} & ~bmask[15:0]) | (pwdata[15:0] & bmask[15:0]);
    assign nxt_ctl = ctl_wr ? ctl_merge[CTL_W-1:0] : ctl_ff;
    assign nxt_issue = ctl_wr & (pstrb[0] | pstrb[1]);

    // Sticky status; a set in the clearing cycle wins
    wire cc_clr   = ctl_wr & pstrb[2] & pwdata[ST_CMD_CPL_BIT];
    wire dll_clr  = ctl_wr & pstrb[3] & pwdata[ST_DLL_CHG_BIT];
    wire dll_chg  = dl_sync_ff ^ dl_prev_ff;
    assign nxt_cc_st  = cmd_done | (cc_st_ff & ~cc_clr);
    assign nxt_dll_st = dll_chg | (dll_st_ff & ~dll_clr);

    // Interrupt and wake pulses
    wire ev_btn   = evt.attn_button & ctl_ff[CTL_ATTN_BTN_EN];
    wire ev_flt   = evt.power_fault & ctl_ff[CTL_PWR_FLT_EN];
    wire ev_latch = evt.retention_latch_sensor & ctl_ff[CTL_LATCH_EN];
    wire ev_pres  = evt.presence_change & ctl_ff[CTL_PRES_EN];
    wire ev_cc    = cmd_done & ctl_ff[CTL_CMD_CPL_EN];
    wire ev_dll   = dll_chg & ctl_ff[CTL_DLL_EN] & DLL_ACTIVE_CAP;
    wire ev_wake  = ev_btn | ev_flt | ev_latch | ev_pres;
    assign nxt_irq  = ctl_ff[CTL_HP_INT_EN] & (ev_wake | ev_cc | ev_dll);
    // Command completion never wakes the system
    assign nxt_wake = ev_wake;

    // Message queue: one pending flag per kind, power limit first
    wire ai_code_ok = (pwdata[CTL_ATTN_LSB+1:CTL_ATTN_LSB] != IND_RSVD);
    wire pi_code_ok = (pwdata[CTL_PIND_LSB+1:CTL_PIND_LSB] != IND_RSVD);
    wire set_pl   = cap_wr & lim_touch & ~ld_valid;
    wire set_ai   = ctl_wr & ai_touch & ai_code_ok;
    wire set_pi   = ctl_wr & pi_touch & pi_code_ok;
    wire slot_free = ~msg_vld_ff | msg_ready;
    wire take_pl  = slot_free & pend_pl_ff;
    wire take_ai  = slot_free & ~pend_pl_ff & pend_ai_ff;
    wire take_pi  = slot_free & ~pend_pl_ff & ~pend_ai_ff & pend_pi_ff;
    assign nxt_pend_pl = set_pl | (pend_pl_ff & ~take_pl);
    assign nxt_pend_ai = set_ai | (pend_ai_ff & ~take_ai);
    assign nxt_pend_pi = set_pi | (pend_pi_ff & ~take_pi);
    assign nxt_msg_vld = (take_pl | take_ai | take_pi) | (msg_vld_ff & ~msg_ready);

    // The message carries the field value current when it is sent
    always_comb begin
        nxt_msg = msg_ff;
        if (take_pl) begin
            nxt_msg = '{kind: HPS_MSG_PWR_LIMIT, ind: IND_RSVD,
                        pwr_val: cap_ff.pwr_val, pwr_scale: cap_ff.pwr_scale};
        end else if (take_ai) begin
            nxt_msg = '{kind: HPS_MSG_ATTN_IND, ind: ctl_ff[CTL_ATTN_LSB+1:CTL_ATTN_LSB],
                        pwr_val: 8'h00, pwr_scale: 2'h0};
        end else if (take_pi) begin
            nxt_msg = '{kind: HPS_MSG_PWR_IND, ind: ctl_ff[CTL_PIND_LSB+1:CTL_PIND_LSB],
                        pwr_val: 8'h00, pwr_scale: 2'h0};
        end
    end

    // Outputs
    assign msg_valid                  = msg_vld_ff;
    assign msg                        = msg_ff;
    assign hp_irq                     = irq_ff;
    assign hp_wake                    = wake_ff;
    assign cmd_issue                  = issue_ff;
    assign pwr_off                    = ctl_ff[CTL_PWR_OFF];
    assign electromechanical_lock_ctl = ctl_ff[CTL_EM_LOCK];
    assign attn_ind                   = ctl_ff[CTL_ATTN_LSB+1:CTL_ATTN_LSB];
    assign pwr_ind                    = ctl_ff[CTL_PIND_LSB+1:CTL_PIND_LSB];

    // Link-active pin synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dl_meta_ff <= 1'b0;
            dl_sync_ff <= 1'b0;
            dl_prev_ff <= 1'b0;
        end else begin
            dl_meta_ff <= dl_active;
            dl_sync_ff <= dl_meta_ff;
            dl_prev_ff <= dl_sync_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_ff    <= '{hp_capable: RST_HP_CAPABLE, pwr_val: RST_PWR_VAL,
                           pwr_scale: RST_PWR_SCALE, slot_num: RST_SLOT_NUM};
            ctl_ff    <= RST_SLOT_CTL;
            cc_st_ff  <= 1'b0;
            dll_st_ff <= 1'b0;
        end else begin
            cap_ff    <= nxt_cap;
            ctl_ff    <= nxt_ctl;
            cc_st_ff  <= nxt_cc_st;
            dll_st_ff <= nxt_dll_st;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_pl_ff <= 1'b0;
            pend_ai_ff <= 1'b0;
            pend_pi_ff <= 1'b0;
            msg_vld_ff <= 1'b0;
            msg_ff     <= '0;
        end else begin
            pend_pl_ff <= nxt_pend_pl;
            pend_ai_ff <= nxt_pend_ai;
            pend_pi_ff <= nxt_pend_pi;
            msg_vld_ff <= nxt_msg_vld;
            msg_ff     <= nxt_msg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
            irq_ff   <= 1'b0;
            wake_ff  <= 1'b0;
            issue_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            irq_ff   <= nxt_irq;
            wake_ff  <= nxt_wake;
            issue_ff <= nxt_issue;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_hp_cap_ro: assert property (
        !ld_valid |=> $stable(cap_ff.hp_capable))
        else $error("hot-plug capable flag changed without a load");

    a_pwr_val_wr: assert property (
        cap_wr && pstrb[0] && pstrb[1] && !ld_valid
        |=> cap_ff.pwr_val == $past(pwdata[CAP_PWR_VAL_MSB:CAP_PWR_VAL_LSB]))
        else $error("power limit value not stored");

    a_pwr_scale_wr: assert property (
        cap_wr && pstrb[1] && pstrb[2] && !ld_valid
        |=> cap_ff.pwr_scale == $past(pwdata[CAP_PWR_SCALE_MSB:CAP_PWR_SCALE_LSB]))
        else $error("power limit scale not stored");

    a_pl_msg_queued: assert property (
        set_pl |=> pend_pl_ff ##[0:4] (msg_valid && msg.kind == HPS_MSG_PWR_LIMIT)
                   or (msg_valid && !msg_ready))
        else $error("power limit write did not reach the message port");

    a_slot_num_ro: assert property (
        !ld_valid |=> $stable(cap_ff.slot_num))
        else $error("slot number changed without a load");

    a_load_applies: assert property (
        ld_valid |=> cap_ff == $past(ld_data))
        else $error("loaded capability defaults not applied");

    a_irq_master: assert property (
        hp_irq |-> $past(ctl_ff[CTL_HP_INT_EN]))
        else $error("interrupt without master enable");

    a_irq_button: assert property (
        evt.attn_button && ctl_ff[CTL_ATTN_BTN_EN] && ctl_ff[CTL_HP_INT_EN]
        |=> hp_irq && hp_wake)
        else $error("enabled attention button event lost");

    a_cc_no_wake: assert property (
        cmd_done && !ev_wake |=> !hp_wake)
        else $error("command completion produced a wake");

    a_ind_msg: assert property (
        take_ai |=> msg_valid && msg.kind == HPS_MSG_ATTN_IND && msg.ind == $past(attn_ind))
        else $error("attention indicator message lost or wrong");

    a_pind_hold: assert property (
        pend_pi_ff && !take_pi |=> pend_pi_ff)
        else $error("power indicator message dropped");

    a_cc_sticky: assert property (
        cmd_done |=> cc_st_ff)
        else $error("command completed flag not set");

    a_dll_sticky: assert property (
        dll_chg |=> dll_st_ff)
        else $error("link state changed flag not set");

    a_rsvd_zero: assert property (
        access && !pwrite && ctl_hit |-> prdata[15:13] == 3'h0)
        else $error("reserved control bits read nonzero");

    c_pl_msg_sent:  cover property (msg_valid && msg_ready && msg.kind == HPS_MSG_PWR_LIMIT);
    c_write_stall:  cover property (access && !pready);
    c_irq_dll:      cover property (dll_chg && ctl_ff[CTL_DLL_EN] ##1 hp_irq);
    c_set_on_clear: cover property (cmd_done && cc_clr);
endmodule
